// ---- verilog/cst_pkg.sv ----
// shared constants and types of the cipher self-test supervisor
package cst_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CAUSE = 12'h008;
  localparam logic [11:0] ADDR_TAG = 12'h00C;
  // control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_DUAL = 0;
  localparam int CTRL_SUBST = 1;
  localparam int CTRL_TESTMODE = 2;
  localparam int CTRL_CF_OVR = 3;
  localparam int CTRL_ARESET = 4;
  localparam int CTRL_ECB_CLR = 5;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // status register fields
  localparam int ST_ALARM = 0;
  localparam int ST_INHIBIT = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_KEYED = 3;
  localparam int ST_SECURE = 4;
  localparam int ST_CWVALID = 5;
  localparam int ST_ECBREF = 6;
  // alarm cause fields
  localparam int CAUSE_W = 12;
  localparam int CA_DUAL = 0;
  localparam int CA_SBOX = 1;
  localparam int CA_CW = 2;
  localparam int CA_CMPTEST = 3;
  localparam int CA_INHTEST = 4;
  localparam int CA_PARTEST = 5;
  localparam int CA_KEYPAR = 6;
  localparam int CA_CTRLFLD = 7;
  localparam int CA_FIELD = 8;
  localparam int CA_TAGMAX = 9;
  localparam int CA_MACTEST = 10;
  localparam int CA_TIMEOUT = 11;
  localparam logic [11:0] CAUSE_RESET = 12'h000;
  // field widths
  localparam int WORD_W = 64;
  localparam int TAG_W = 16;
  localparam int MAC_W = 32;
  localparam logic [15:0] TAG_MAX = 16'hFFFF;
  // timing counts in pclk cycles
  localparam logic [7:0] TEST_TIMEOUT_CYC = 8'hFF;
  localparam logic [7:0] CF_WAIT_CYC = 8'h40;
  // good-parity word with one bit flipped in byte 0
  localparam logic [63:0] PAR_TEST_WORD = 64'h0101010101010100;
  // stored known-answer of the table test; value is arbitrary
  localparam logic [63:0] SBOX_EXPECT_DEFAULT = 64'h5A5A_0F0F_C3C3_9696;
  // codebook purposes that are allowed, then the known-answer test selects
  localparam logic [1:0] ECB_DATA_KEY = 2'h0;
  localparam logic [1:0] ECB_IV = 2'h1;
  localparam logic TEST_SEL_SBOX = 1'b0;
  localparam logic TEST_SEL_CW = 1'b1;
  typedef enum logic [10:0] {
    S_IDLE = 11'b000_0000_0001,
    S_SBOX_REQ = 11'b000_0000_0010,
    S_SBOX_WAIT = 11'b000_0000_0100,
    S_CW_REQ = 11'b000_0000_1000,
    S_CW_WAIT = 11'b000_0001_0000,
    S_CMP_FORCE = 11'b000_0010_0000,
    S_INH_TEST = 11'b000_0100_0000,
    S_PAR_TEST = 11'b000_1000_0000,
    S_CF_GOOD = 11'b001_0000_0000,
    S_CF_BAD = 11'b010_0000_0000,
    S_DONE = 11'b100_0000_0000
  } cst_state_t;
endpackage

// ---- verilog/cst_supervisor.sv ----
// self-test and alarm supervisor gating ciphertext output
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps

// comparator whose xor tree can be proven by a forced mismatch
module cst_cmp #(
  parameter int W = 64
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic force_err,
  output logic mismatch
);
  wire logic [W-1:0] eff_a;
  wire logic [W-1:0] eff_b;
  assign eff_a = force_err ? (a ^ {{(W-1){1'b0}}, 1'b1}) : a;
  assign eff_b = force_err ? a : b;
  assign mismatch = (eff_a != eff_b);
endmodule // cst_cmp

module cst_supervisor
  import cst_pkg::*;
#(
  parameter logic [63:0] SBOX_EXPECT = SBOX_EXPECT_DEFAULT
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cipher datapath
  input wire logic [63:0] eng_a_word,
  input wire logic [63:0] eng_b_word,
  input wire logic eng_word_valid,
  output logic test_req,
  output logic test_sel,
  input wire logic test_done,
  input wire logic [63:0] test_word,
  // key and vector events
  input wire logic key_entry,
  input wire logic [63:0] key_word,
  input wire logic key_word_valid,
  input wire logic key_transfer,
  input wire logic zeroize_active,
  input wire logic nonplain_use,
  input wire logic iv_use_req,
  output logic iv_grant,
  input wire logic ecb_req,
  input wire logic [1:0] ecb_kind,
  output logic ecb_grant,
  // received field checks
  input wire logic [TAG_W-1:0] rx_chain_sequence_tag,
  input wire logic [TAG_W-1:0] exp_chain_sequence_tag,
  input wire logic rx_tag_valid,
  input wire logic [63:0] rx_mdc,
  input wire logic [63:0] exp_mdc,
  input wire logic rx_mdc_valid,
  input wire logic [MAC_W-1:0] rx_message_auth_code,
  input wire logic [MAC_W-1:0] exp_message_auth_code,
  input wire logic mac_valid,
  // chain tag generation
  input wire logic tag_advance,
  output logic [TAG_W-1:0] tx_chain_sequence_tag,
  // control field recogniser
  output logic ctrl_inject,
  output logic ctrl_inject_corrupt,
  input wire logic ctrl_field_seen,
  // supervisor outputs
  output logic ct_inhibit,
  output logic alarm,
  output logic secure_enable,
  output logic selftest_busy
);
  cst_state_t state_reg, state_next;
  logic [CTRL_W-1:0] cfg_reg;
  logic [CAUSE_W-1:0] cause_reg, cause_next;
  logic [63:0] checkword_reg;
  logic [7:0] timer_reg;
  logic [3:0] inh_force_reg;
  logic [TAG_W-1:0] tag_ctr_reg;
  logic [31:0] prdata_reg;
  logic alarm_reg, ct_inhibit_reg, secure_enable_reg, busy_reg;
  logic cw_valid_reg, keyed_reg, seq_full_reg, seq_newkey_reg, seq_rerun_reg, seq_fail_reg;
  logic key_pend_reg, iv_pend_reg, rerun_pend_reg, mac_pend_reg;
  logic test_req_reg, test_sel_reg, iv_grant_reg, ecb_grant_reg, ecb_refused_reg;
  logic ctrl_inject_reg, ctrl_corrupt_reg, pready_reg, pslverr_reg;

  // bus decode
  wire logic sel_setup = psel & ~penable;
  wire logic wr_fire = psel & penable & pwrite & pready_reg;
  wire logic hit_ctrl = (paddr == ADDR_CTRL);
  wire logic hit_status = (paddr == ADDR_STATUS);
  wire logic hit_cause = (paddr == ADDR_CAUSE);
  wire logic hit_tag = (paddr == ADDR_TAG);
  wire logic hit_any = hit_ctrl | hit_status | hit_cause | hit_tag;
  wire logic wr_ctrl = wr_fire & hit_ctrl;
  wire logic areset_cmd = wr_ctrl & pwdata[CTRL_ARESET];
  wire logic ecb_clr = wr_ctrl & pwdata[CTRL_ECB_CLR];
  wire logic [6:0] status_vec = {ecb_refused_reg, cw_valid_reg, secure_enable_reg, keyed_reg,
    busy_reg, ct_inhibit_reg, alarm_reg};
  wire logic [31:0] rd_mux =
    hit_ctrl ? {28'h0000000, cfg_reg} :
    hit_status ? {25'h0000000, status_vec} :
    hit_cause ? {20'h00000, cause_reg} :
    hit_tag ? {16'h0000, tag_ctr_reg} : 32'h00000000;

  // state decode
  wire logic st_idle = (state_reg == S_IDLE);
  wire logic st_sbox_wait = (state_reg == S_SBOX_WAIT);
  wire logic st_cw_wait = (state_reg == S_CW_WAIT);
  wire logic st_cmp = (state_reg == S_CMP_FORCE);
  wire logic st_inh = (state_reg == S_INH_TEST);
  wire logic st_par = (state_reg == S_PAR_TEST);
  wire logic st_cf_good = (state_reg == S_CF_GOOD);
  wire logic st_cf_bad = (state_reg == S_CF_BAD);
  wire logic st_done = (state_reg == S_DONE);
  wire logic dual = cfg_reg[CTRL_DUAL];
  wire logic cf_ovr = cfg_reg[CTRL_CF_OVR];
  wire logic timer_zero = (timer_reg == 8'h00);
  wire logic take_key = st_idle & key_pend_reg;
  wire logic take_rerun = st_idle & ~key_pend_reg & rerun_pend_reg;
  wire logic take_iv = st_idle & ~key_pend_reg & ~rerun_pend_reg & iv_pend_reg;
  wire logic cw_compare = st_cw_wait & test_done & ~seq_newkey_reg;

  // a real word, tag or mdc check arriving in the forced cycle defers the forced test
  wire logic cmp_stall = eng_word_valid | rx_tag_valid | rx_mdc_valid;
  wire logic cmp_force = st_cmp & ~cmp_stall;
  wire logic par_force = st_par & ~key_word_valid;
  wire logic mac_force = mac_pend_reg & ~mac_valid;

  // comparators
  wire logic [63:0] test_ref = test_sel_reg ? checkword_reg : SBOX_EXPECT;
  wire logic test_mm, dual_mm, tag_mm, mdc_mm, mac_mm;
  cst_cmp #(.W(WORD_W)) u_cmp_test (.a(test_word), .b(test_ref), .force_err(cmp_force),
    .mismatch(test_mm));
  cst_cmp #(.W(WORD_W)) u_cmp_dual (.a(eng_a_word), .b(eng_b_word), .force_err(cmp_force),
    .mismatch(dual_mm));
  cst_cmp #(.W(TAG_W)) u_cmp_tag (.a(rx_chain_sequence_tag), .b(exp_chain_sequence_tag),
    .force_err(cmp_force), .mismatch(tag_mm));
  cst_cmp #(.W(WORD_W)) u_cmp_mdc (.a(rx_mdc), .b(exp_mdc), .force_err(cmp_force),
    .mismatch(mdc_mm));
  cst_cmp #(.W(MAC_W)) u_cmp_mac (.a(rx_message_auth_code), .b(exp_message_auth_code),
    .force_err(mac_force), .mismatch(mac_mm));

  // odd parity of every key byte
  wire logic [63:0] par_in = par_force ? PAR_TEST_WORD : key_word;
  logic [7:0] byte_even;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_par
      assign byte_even[gi] = ~(^par_in[8*gi +: 8]);
    end
  endgenerate
  wire logic par_bad = |byte_even;

  // inhibit combiner, each leg can be forced during its own test
  wire logic [3:0] inh_cond = {nonplain_use, cfg_reg[CTRL_TESTMODE], zeroize_active,
    key_transfer} | inh_force_reg;
  wire logic inh_any = |inh_cond;
  wire logic tag_at_max = (tag_ctr_reg == TAG_MAX);

  // alarm causes
  logic [CAUSE_W-1:0] cause_set;
  always_comb
  begin
    cause_set = CAUSE_RESET;
    cause_set[CA_DUAL] = dual & eng_word_valid & dual_mm;
    cause_set[CA_SBOX] = st_sbox_wait & test_done & test_mm;
    cause_set[CA_CW] = cw_compare & test_mm;
    cause_set[CA_CMPTEST] = cmp_force & ~(test_mm & dual_mm);
    cause_set[CA_INHTEST] = st_inh & ~inh_any;
    cause_set[CA_PARTEST] = par_force & ~par_bad;
    cause_set[CA_KEYPAR] = key_word_valid & par_bad;
    cause_set[CA_CTRLFLD] = (st_cf_good & timer_zero & ~ctrl_field_seen) |
      (st_cf_bad & ctrl_field_seen);
    cause_set[CA_FIELD] = (rx_tag_valid & tag_mm) | (rx_mdc_valid & mdc_mm) |
      (mac_valid & mac_mm) | (cmp_force & ~(tag_mm & mdc_mm));
    cause_set[CA_TAGMAX] = tag_at_max;
    cause_set[CA_MACTEST] = mac_force & ~mac_mm;
    cause_set[CA_TIMEOUT] = (st_sbox_wait | st_cw_wait) & timer_zero & ~test_done;
  end

  // causes clear only when a rerun finishes clean; a new cause wins
  wire logic rerun_pass = st_done & seq_rerun_reg & ~seq_fail_reg & ~(|cause_set);
  assign cause_next = (rerun_pass ? CAUSE_RESET : cause_reg) | cause_set;
  wire logic alarm_next = |cause_next;
  wire logic ct_inhibit_next = alarm_next | inh_any | ~st_idle | ~keyed_reg;
  wire logic secure_next = ~alarm_next & keyed_reg & ~zeroize_active & st_idle;
  wire logic ecb_ok_kind = (ecb_kind == ECB_DATA_KEY) | (ecb_kind == ECB_IV);
  wire logic seq_ok = ~seq_fail_reg & ~(|cause_set);

  // sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:
      begin
        if (take_key | take_rerun)
          state_next = dual ? S_CMP_FORCE : S_SBOX_REQ;
        else if (take_iv)
          state_next = dual ? S_CMP_FORCE :
            (cfg_reg[CTRL_SUBST] ? S_SBOX_REQ : S_CW_REQ);
      end
      S_SBOX_REQ: state_next = S_SBOX_WAIT;
      S_SBOX_WAIT:
      begin
        if (test_done | timer_zero)
          state_next = seq_full_reg ? S_CW_REQ : S_CMP_FORCE;
      end
      S_CW_REQ: state_next = S_CW_WAIT;
      S_CW_WAIT:
      begin
        if (test_done | timer_zero)
          state_next = S_CMP_FORCE;
      end
      S_CMP_FORCE:
      begin
        if (~cmp_stall)
          state_next = seq_full_reg ? S_INH_TEST : (cf_ovr ? S_DONE : S_CF_GOOD);
      end
      S_INH_TEST:
      begin
        if (inh_force_reg[3])
          state_next = S_PAR_TEST;
      end
      S_PAR_TEST:
      begin
        if (~key_word_valid)
          state_next = cf_ovr ? S_DONE : S_CF_GOOD;
      end
      S_CF_GOOD:
      begin
        if (ctrl_field_seen | timer_zero)
          state_next = S_CF_BAD;
      end
      S_CF_BAD:
      begin
        if (ctrl_field_seen | timer_zero)
          state_next = S_DONE;
      end
      S_DONE: state_next = S_IDLE;
    endcase
  end

  wire logic entering = (state_next != state_reg);
  wire logic to_cf = (state_next == S_CF_GOOD) | (state_next == S_CF_BAD);
  wire logic to_req = (state_next == S_SBOX_WAIT) | (state_next == S_CW_WAIT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= S_IDLE;
      timer_reg <= 8'h00;
      inh_force_reg <= 4'h0;
      seq_full_reg <= 1'b0;
      seq_newkey_reg <= 1'b0;
      seq_rerun_reg <= 1'b0;
      seq_fail_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (entering)
        timer_reg <= to_cf ? CF_WAIT_CYC : TEST_TIMEOUT_CYC;
      else if (!timer_zero)
        timer_reg <= timer_reg - 8'h01;
      inh_force_reg <= (state_next == S_INH_TEST) ?
        (st_inh ? {inh_force_reg[2:0], 1'b0} : 4'h1) : 4'h0;
      if (st_idle)
      begin
        seq_full_reg <= take_key | take_rerun;
        seq_newkey_reg <= take_key;
        seq_rerun_reg <= take_rerun;
        seq_fail_reg <= 1'b0;
      end
      else if (|cause_set)
        seq_fail_reg <= 1'b1;
    end
  end

  // key, checkword and tag state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      checkword_reg <= 64'h0000000000000000;
      cw_valid_reg <= 1'b0;
      keyed_reg <= 1'b0;
      tag_ctr_reg <= 16'h0000;
      key_pend_reg <= 1'b0;
      iv_pend_reg <= 1'b0;
      rerun_pend_reg <= 1'b0;
      mac_pend_reg <= 1'b0;
    end
    else
    begin
      key_pend_reg <= key_entry | (key_pend_reg & ~take_key);
      iv_pend_reg <= iv_use_req | (iv_pend_reg & ~take_iv);
      rerun_pend_reg <= areset_cmd | (rerun_pend_reg & ~take_rerun);
      mac_pend_reg <= mac_valid | (mac_pend_reg & ~mac_force);
      if (key_entry | zeroize_active)
      begin
        cw_valid_reg <= 1'b0;
        keyed_reg <= 1'b0;
        checkword_reg <= 64'h0000000000000000;
      end
      else
      begin
        if (st_cw_wait & test_done & seq_newkey_reg & seq_ok)
        begin
          checkword_reg <= test_word;
          cw_valid_reg <= 1'b1;
        end
        if (st_done & seq_newkey_reg & seq_ok)
          keyed_reg <= 1'b1;
      end
      // a fresh key opens a fresh tag period; at the top the count holds
      if (key_entry)
        tag_ctr_reg <= 16'h0000;
      else if (tag_advance & ~tag_at_max)
        tag_ctr_reg <= tag_ctr_reg + 16'h0001;
    end
  end

  // alarm and output flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cause_reg <= CAUSE_RESET;
      alarm_reg <= 1'b0;
      ct_inhibit_reg <= 1'b1;
      secure_enable_reg <= 1'b0;
      busy_reg <= 1'b0;
      test_req_reg <= 1'b0;
      test_sel_reg <= TEST_SEL_SBOX;
      iv_grant_reg <= 1'b0;
      ecb_grant_reg <= 1'b0;
      ecb_refused_reg <= 1'b0;
      ctrl_inject_reg <= 1'b0;
      ctrl_corrupt_reg <= 1'b0;
    end
    else
    begin
      cause_reg <= cause_next;
      alarm_reg <= alarm_next;
      ct_inhibit_reg <= ct_inhibit_next;
      secure_enable_reg <= secure_next;
      busy_reg <= (state_next != S_IDLE);
      test_req_reg <= entering & to_req;
      if (entering & to_req)
        test_sel_reg <= (state_next == S_CW_WAIT) ? TEST_SEL_CW : TEST_SEL_SBOX;
      iv_grant_reg <= st_done & ~seq_full_reg & seq_ok & ~alarm_reg;
      ecb_grant_reg <= ecb_req & ecb_ok_kind & keyed_reg & ~alarm_reg;
      ecb_refused_reg <= (ecb_req & ~ecb_ok_kind) | (ecb_refused_reg & ~ecb_clr);
      ctrl_inject_reg <= entering & to_cf;
      ctrl_corrupt_reg <= (state_next == S_CF_BAD);
    end
  end

  // register file and bus answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg <= CTRL_RESET;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= sel_setup;
      if (sel_setup)
      begin
        prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_reg <= ~hit_any;
      end
      if (wr_ctrl)
        cfg_reg <= pwdata[CTRL_W-1:0];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign test_req = test_req_reg;
  assign test_sel = test_sel_reg;
  assign iv_grant = iv_grant_reg;
  assign ecb_grant = ecb_grant_reg;
  assign tx_chain_sequence_tag = tag_ctr_reg;
  assign ctrl_inject = ctrl_inject_reg;
  assign ctrl_inject_corrupt = ctrl_corrupt_reg;
  assign ct_inhibit = ct_inhibit_reg;
  assign alarm = alarm_reg;
  assign secure_enable = secure_enable_reg;
  assign selftest_busy = busy_reg;
endmodule // cst_supervisor

// ---- dv/cst_chk.sv ----
// concurrent checks on the self-test supervisor ports
`timescale 1ns/100ps
module cst_chk
  import cst_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // datapath and events
  input wire logic test_req,
  input wire logic key_entry,
  input wire logic key_transfer,
  input wire logic zeroize_active,
  input wire logic nonplain_use,
  input wire logic ecb_req,
  input wire logic [1:0] ecb_kind,
  input wire logic ecb_grant,
  input wire logic iv_grant,
  // field checks and tags
  input wire logic [TAG_W-1:0] rx_chain_sequence_tag,
  input wire logic [TAG_W-1:0] exp_chain_sequence_tag,
  input wire logic rx_tag_valid,
  input wire logic tag_advance,
  input wire logic [TAG_W-1:0] tx_chain_sequence_tag,
  // supervisor outputs
  input wire logic ct_inhibit,
  input wire logic alarm,
  input wire logic secure_enable,
  input wire logic selftest_busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RESET_INHIBIT: assert property ($rose(presetn) |-> ct_inhibit)
    else $error("inhibit low right after reset");
  AST_ALARM_INHIBIT: assert property (alarm |-> ct_inhibit)
    else $error("alarm without inhibit");
  AST_COND_INHIBIT: assert property ((key_transfer || zeroize_active || nonplain_use)
    |=> ct_inhibit)
    else $error("inhibit condition not blocking");
  AST_ALARM_HOLD: assert property ($fell(alarm)
    |-> $past(selftest_busy) || $past(selftest_busy, 2))
    else $error("alarm cleared without rerun");
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_TAG_STEP: assert property (tag_advance && !key_entry && tx_chain_sequence_tag != TAG_MAX
    |=> tx_chain_sequence_tag == $past(tx_chain_sequence_tag) + 16'h0001)
    else $error("tag did not step by one");
  AST_TAG_HOLD: assert property (tx_chain_sequence_tag == TAG_MAX && !key_entry
    |=> tx_chain_sequence_tag == TAG_MAX)
    else $error("tag wrapped");
  AST_FIELD_ALARM: assert property (rx_tag_valid && rx_chain_sequence_tag != exp_chain_sequence_tag
    |=> alarm)
    else $error("tag mismatch without alarm");
  AST_ECB_KIND: assert property (ecb_grant |-> $past(ecb_req) && $past(ecb_kind) < 2'h2)
    else $error("codebook granted for bad purpose");
  AST_SECURE_OFF: assert property (alarm |-> !secure_enable)
    else $error("secure mode during alarm");
  AST_ZERO_SECURE: assert property (zeroize_active |=> !secure_enable)
    else $error("secure mode while zeroizing");
  AST_IV_CLEAN: assert property (iv_grant |-> !alarm)
    else $error("vector granted during alarm");
  AST_REQ_PULSE: assert property (test_req |=> !test_req)
    else $error("test request longer than a pulse");
  cover property (iv_grant);
  cover property (ecb_grant);
  cover property ($fell(alarm));
  cover property (test_req);
endmodule // cst_chk

bind cst_supervisor cst_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .test_req,
  .key_entry, .key_transfer, .zeroize_active, .nonplain_use, .ecb_req, .ecb_kind, .ecb_grant,
  .iv_grant, .rx_chain_sequence_tag, .exp_chain_sequence_tag, .rx_tag_valid, .tag_advance,
  .tx_chain_sequence_tag, .ct_inhibit, .alarm, .secure_enable, .selftest_busy);

// ---- dv/cst_partner.sv ----
// behavioural known-answer engine and control-field recogniser
`timescale 1ns/100ps
module cst_partner
  import cst_pkg::*;
#(
  parameter logic [63:0] SBOX_K = SBOX_EXPECT_DEFAULT,
  parameter logic [63:0] CW_K = 64'h0F1E_2D3C_4B5A_6978
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench knobs
  input wire logic bad_answer,
  input wire logic slow,
  // known-answer engine
  input wire logic test_req,
  input wire logic test_sel,
  output logic test_done,
  output logic [63:0] test_word,
  // recogniser
  input wire logic ctrl_inject,
  input wire logic ctrl_inject_corrupt,
  output logic ctrl_field_seen
);
  logic [5:0] cnt;
  logic sel_q;
  logic [1:0] cf;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 6'h00;
      sel_q <= 1'b0;
      cf <= 2'h0;
      test_done <= 1'b0;
      test_word <= 64'h0;
      ctrl_field_seen <= 1'b0;
    end
    else
    begin
      test_done <= 1'b0;
      // result bus is stale outside done: keep it moving so it is never trusted
      test_word <= ~test_word;
      if (cnt != 6'h00)
        cnt <= cnt - 6'h01;
      if (test_req)
      begin
        cnt <= slow ? 6'h1E : 6'h02;
        sel_q <= test_sel;
      end
      else if (cnt == 6'h01)
      begin
        test_done <= 1'b1;
        test_word <= (sel_q ? CW_K : SBOX_K) ^ {63'h0, bad_answer};
      end
      // a corrupted start field is never recognised
      cf <= {cf[0], ctrl_inject && !ctrl_inject_corrupt};
      ctrl_field_seen <= cf[1];
    end
  end
endmodule // cst_partner

// ---- dv/tb.sv ----
// self-checking bench of the self-test supervisor
`timescale 1ns/100ps
module tb
  import cst_pkg::*;
;
  localparam logic [63:0] SBOX_K = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] KEY_OK = 64'h0101_0101_0101_0101;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [63:0] eng_a_word, eng_b_word, test_word, key_word, rx_mdc, exp_mdc;
  logic eng_word_valid, test_req, test_sel, test_done, key_entry, key_word_valid, key_transfer;
  logic zeroize_active, nonplain_use, iv_use_req, iv_grant, ecb_req, ecb_grant, rx_tag_valid;
  logic rx_mdc_valid, mac_valid, tag_advance, ctrl_inject, ctrl_inject_corrupt, ctrl_field_seen;
  logic ct_inhibit, alarm, secure_enable, selftest_busy, bad, slow, got_iv, last_sel;
  logic [1:0] ecb_kind;
  logic [TAG_W-1:0] rx_chain_sequence_tag, exp_chain_sequence_tag, tx_chain_sequence_tag;
  logic [MAC_W-1:0] rx_message_auth_code, exp_message_auth_code;
  logic [2:0] leg [4] = '{3'b001, 3'b010, 3'b000, 3'b100};
  logic [32:0] exp_q [$];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  cst_supervisor #(.SBOX_EXPECT(SBOX_K)) dut (.*);
  cst_partner #(.SBOX_K(SBOX_K)) u_partner (.pclk, .presetn, .bad_answer(bad), .slow,
    .test_req, .test_sel, .test_done, .test_word, .ctrl_inject, .ctrl_inject_corrupt,
    .ctrl_field_seen);
  always #5 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic got, input logic ex);
    cmp_count++;
    if (got !== ex)
    begin
      n_errors++;
      $display("MISMATCH %s exp %b got %b", nm, ex, got);
    end
  endtask
  task chk_rd(input logic [11:0] a, input logic [32:0] got, input logic [32:0] ex);
    cmp_count++;
    if (got !== ex)
    begin
      n_errors++;
      $display("MISMATCH read %h exp %h got %h", a, ex, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // reads note {pslverr, prdata} expected; the monitor takes it when the answer lands
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back({a > ADDR_TAG, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task idle;
    tick(3);
    while (selftest_busy !== 1'b0) @(posedge pclk);
    tick(3);
  endtask
  task load(input logic [63:0] w);
    key_entry <= 1'b1;
    key_word_valid <= 1'b1;
    key_word <= w;
    @(posedge pclk);
    key_entry <= 1'b0;
    key_word_valid <= 1'b0;
    idle;
  endtask
  task rearm(input logic [31:0] c);
    apb(1'b1, ADDR_CTRL, c);
    idle;
  endtask
  task vec;
    iv_use_req <= 1'b1;
    @(posedge pclk);
    iv_use_req <= 1'b0;
    got_iv = 1'b0;
    for (int n = 0; n < 800 && !got_iv; n++)
    begin
      @(posedge pclk);
      if (iv_grant === 1'b1) got_iv = 1'b1;
    end
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (test_req === 1'b1) last_sel <= test_sel;
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk_rd(paddr, {pslverr, prdata}, exp_q.pop_front());
    if (cyc == 90000)
    begin
      n_errors++;
      close_out;
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, eng_word_valid, key_entry} = '0;
    {key_word_valid, key_transfer, zeroize_active, nonplain_use, iv_use_req, ecb_req} = '0;
    {rx_tag_valid, rx_mdc_valid, mac_valid, tag_advance, bad, slow, ecb_kind} = '0;
    {eng_a_word, eng_b_word, key_word, rx_mdc, exp_mdc} = '0;
    {rx_chain_sequence_tag, exp_chain_sequence_tag} = '0;
    {rx_message_auth_code, exp_message_auth_code} = '0;
    seed = 32'h6EA9533C;
    tick(6);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("ct_inhibit", ct_inhibit, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    slow <= 1'b1;
    load(KEY_OK);
    slow <= 1'b0;
    chk("alarm", alarm, 1'b0);
    chk("ct_inhibit", ct_inhibit, 1'b0);
    chk("secure", secure_enable, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h38);
    apb(1'b0, ADDR_CAUSE, 32'h0);
    repeat (3)
    begin
      tag_advance <= 1'b1;
      @(posedge pclk);
      tag_advance <= 1'b0;
      @(posedge pclk);
    end
    apb(1'b1, ADDR_TAG, 32'hFF);
    apb(1'b0, ADDR_TAG, 32'h3);
    chk("tag", tx_chain_sequence_tag == 16'h3, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      ecb_req <= 1'b1;
      ecb_kind <= k[1:0];
      @(posedge pclk);
      ecb_req <= 1'b0;
      @(posedge pclk);
      chk("ecb_grant", ecb_grant, k < 2);
    end
    apb(1'b0, ADDR_STATUS, 32'h78);
    apb(1'b1, ADDR_CTRL, 32'h20);
    apb(1'b0, ADDR_STATUS, 32'h38);
    // zeroize last: it drops the key, so a reload follows
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2) apb(1'b1, ADDR_CTRL, 32'h4);
      {zeroize_active, nonplain_use, key_transfer} <= leg[i];
      tick(2);
      chk("ct_inhibit", ct_inhibit, 1'b1);
      {zeroize_active, nonplain_use, key_transfer} <= 3'b000;
      if (i == 2) apb(1'b1, ADDR_CTRL, 32'h0);
      tick(2);
      if (i < 3) chk("ct_inhibit", ct_inhibit, 1'b0);
    end
    load(KEY_OK);
    vec;
    chk("iv_grant", got_iv, 1'b1);
    chk("test_sel", last_sel, TEST_SEL_CW);
    apb(1'b1, ADDR_CTRL, 32'h2);
    vec;
    chk("test_sel", last_sel, TEST_SEL_SBOX);
    apb(1'b1, ADDR_CTRL, 32'h0);
    bad <= 1'b1;
    vec;
    chk("iv_grant", got_iv, 1'b0);
    chk("alarm", alarm, 1'b1);
    apb(1'b0, ADDR_CAUSE, 32'h4);
    bad <= 1'b0;
    rearm(32'h10);
    chk("alarm", alarm, 1'b0);
    r = xs(seed);
    seed = r;
    {rx_message_auth_code, exp_message_auth_code, rx_mdc, exp_mdc} <= {r, r, {2{r}}, {2{r}}};
    {mac_valid, rx_mdc_valid} <= 2'b11;
    @(posedge pclk);
    {mac_valid, rx_mdc_valid} <= 2'b00;
    tick(4);
    chk("alarm", alarm, 1'b0);
    rx_chain_sequence_tag <= r[15:0];
    exp_chain_sequence_tag <= r[15:0] ^ 16'h8000;
    rx_tag_valid <= 1'b1;
    @(posedge pclk);
    rx_tag_valid <= 1'b0;
    tick(2);
    chk("alarm", alarm, 1'b1);
    chk("secure", secure_enable, 1'b0);
    rearm(32'h10);
    chk("alarm", alarm, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    for (int j = 0; j < 2; j++)
    begin
      r = xs(seed);
      seed = r;
      eng_a_word <= {r, r};
      eng_b_word <= {r, r ^ {31'h0, j[0]}};
      eng_word_valid <= 1'b1;
      @(posedge pclk);
      eng_word_valid <= 1'b0;
      tick(2);
      chk("alarm", alarm, j[0]);
    end
    rearm(32'h11);
    chk("alarm", alarm, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0);
    load(PAR_TEST_WORD);
    chk("alarm", alarm, 1'b1);
    chk("ct_inhibit", ct_inhibit, 1'b1);
    tag_advance <= 1'b1;
    tick(65536);
    apb(1'b0, ADDR_CAUSE, 32'h240);
    close_out;
  end
endmodule // tb
